// *** rtl/aesd_consts.svh ***
// constants for the pipelined aes-256 block decryptor
// Operation
// R1: one clock, active-low reset returns idle
// R2: constant 32-bit revision output
// R3: key strobe while idle captures key, expands
// R4: user holds key valid with strobe
// R5: key busy until final cycle, strobes ignored
// R6: done flag only in final expansion cycle
// R7: key busy low 14 cycles after strobe
// R8: expanded key kept until next load
// R9: ciphertext taken each strobed cycle
// R10: user holds ciphertext valid with strobe
// R11: one block per cycle, no stalls
// R12: decrypt busy rises cycle after accept
// R13: key strobe ignored while decrypt busy
// R14: plaintext valid 15 cycles after accept
// R15: plaintext meaningful only while valid
// R16: 14 idle cycles give one drain pulse
// R17: decrypt busy clears after drain pulse
// R18: blocks resume after drain, same key
// R19: standard aes-256 inverse cipher, ecb
`ifndef AESD_CONSTS_SVH
`define AESD_CONSTS_SVH
`define AESD_KEY_W 256
`define AESD_BLK_W 128
`define AESD_NR 14
`define AESD_KEY_LAST 4'hD
`define AESD_KEY_DONE 4'hE
`define AESD_DRAIN_IDLE 14
`define AESD_REVISION 32'h0000A5C3
`define AESD_POLY 8'h1B
`define AESD_AFF_C 8'h63
`define AESD_IAFF_C 8'h05
`define AESD_RCON_INIT 8'h01
`define AESD_OFF_REV 4'h0
`define AESD_OFF_CTRL 4'h4
`define AESD_OFF_STAT 4'h8
`define AESD_CTRL_RST 1'b1
`define AESD_RESP_OKAY 2'h0
`define AESD_RESP_SLVERR 2'h2
`endif

// *** rtl/aesd_pkg.sv ***
// shared types of the aes-256 decryptor
package aesd_pkg;
  typedef logic [7:0] aesd_byte_t;
  typedef logic [31:0] aesd_word_t;
  typedef logic [127:0] aesd_blk_t;
endpackage

// *** rtl/aesd_top.sv ***
// pipelined aes-256 ecb decryptor with axi4-lite control registers
`timescale 1ns/1ps
`include "aesd_consts.svh"
module aesd_top import aesd_pkg::*; #(
  parameter int DRAIN_IDLE = `AESD_DRAIN_IDLE,
  parameter logic [31:0] REVISION = `AESD_REVISION // value arbitrary
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // revision
  output logic [31:0] revision,
  // key loading
  input wire logic key_load_strobe,
  input wire logic [255:0] key_value,
  output logic key_expand_busy,
  output logic key_expand_done,
  // ciphertext in
  input wire logic ct_valid_strobe,
  input wire logic [127:0] ciphertext_block,
  output logic decrypt_busy,
  output logic drain_done_pulse,
  // plaintext out
  output logic plaintext_valid,
  output logic [127:0] plaintext_block,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (DRAIN_IDLE < 1 || DRAIN_IDLE > 15) begin : g_chk
    $error("DRAIN_IDLE must lie in 1..15");
  end
  localparam logic [3:0] DRAIN_CMP = 4'(DRAIN_IDLE - 1);
  // gf(2^8) arithmetic
  function automatic aesd_byte_t gmul(input aesd_byte_t a, input aesd_byte_t b);
    aesd_byte_t p, x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? `AESD_POLY : 8'h00);
    end
    return p;
  endfunction
  // x^254 is the field inverse, zero maps to zero
  function automatic aesd_byte_t ginv(input aesd_byte_t x);
    aesd_byte_t r;
    r = x;
    for (int i = 0; i < 6; i++) r = gmul(gmul(r, r), x);
    return gmul(r, r);
  endfunction
  function automatic aesd_byte_t sbox(input aesd_byte_t x);
    aesd_byte_t v;
    v = ginv(x);
    return v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]} ^ {v[3:0], v[7:4]}
      ^ `AESD_AFF_C;
  endfunction
  function automatic aesd_byte_t isbox(input aesd_byte_t x);
    return ginv({x[6:0], x[7]} ^ {x[4:0], x[7:5]} ^ {x[1:0], x[7:2]} ^ `AESD_IAFF_C);
  endfunction
  function automatic aesd_word_t subword(input aesd_word_t w);
    aesd_word_t o;
    o = '0;
    for (int i = 0; i < 4; i++) o[8*i +: 8] = sbox(w[8*i +: 8]);
    return o;
  endfunction
  // one inverse round: shift rows, sub bytes, add key, mix columns unless last
  function automatic aesd_blk_t inv_round(input aesd_blk_t s, input aesd_blk_t k,
                                          input logic last);
    aesd_blk_t t, o;
    aesd_byte_t m;
    logic [31:0] coef;
    t = '0;
    o = '0;
    coef = 32'h0E0B0D09;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        t[127-8*(r+4*c) -: 8] = isbox(s[127-8*(r+4*((c-r)&3)) -: 8]);
      end
    end
    t = t ^ k;
    if (last) begin
      o = t;
    end else begin
      for (int c = 0; c < 4; c++) begin
        for (int j = 0; j < 4; j++) begin
          m = 8'h00;
          for (int i = 0; i < 4; i++) begin
            m = m ^ gmul(t[127-32*c-8*i -: 8], coef[31-8*((i-j)&3) -: 8]);
          end
          o[127-32*c-8*j -: 8] = m;
        end
      end
    end
    return o;
  endfunction

  // control state
  logic en_q, en_d, key_ready_q, key_ready_d, kbusy_q, kbusy_d, kdone_q, kdone_d;
  logic [3:0] kcnt_q, kcnt_d, idle_q, idle_d;
  logic [7:0] rcon_q, rcon_d;
  logic [255:0] win_q, win_d;
  aesd_blk_t rk_q [0:14], rk_d [0:14], st_q [0:14], st_d [0:14];
  logic dbusy_q, dbusy_d, drain_q, drain_d, ct_acc, key_acc;
  logic [14:0] vld_q, vld_d;
  aesd_word_t kt, nw [0:3];

  // accept gating
  assign ct_acc = ct_valid_strobe && !kbusy_q && en_q; // [R5] [R9] [R11] [R18]
  // a block in the same cycle wins, so the key never changes under live data
  assign key_acc = key_load_strobe && !kbusy_q && !dbusy_q && !ct_valid_strobe
                   && en_q; // [R3] [R5] [R13]

  // key expansion, one round key per cycle
  always_comb begin
    kcnt_d = kcnt_q;
    kbusy_d = 1'b0;
    kdone_d = 1'b0;
    rcon_d = rcon_q;
    win_d = win_q;
    key_ready_d = key_ready_q;
    for (int i = 0; i < 15; i++) rk_d[i] = rk_q[i];
    kt = win_q[31:0];
    for (int i = 0; i < 4; i++) nw[i] = '0;
    if (key_acc) begin
      kcnt_d = 4'h1;
      kbusy_d = 1'b1;
      rcon_d = `AESD_RCON_INIT;
      win_d = key_value; // [R3]
      rk_d[0] = key_value[255:128];
      rk_d[1] = key_value[127:0];
      key_ready_d = 1'b0;
    end else if (kcnt_q != 4'h0 && kcnt_q <= `AESD_KEY_LAST) begin
      if (!kcnt_q[0]) begin
        kt = subword(win_q[31:0]);
      end else begin
        kt = subword({win_q[23:0], win_q[31:24]}) ^ {rcon_q, 24'h000000};
        rcon_d = {rcon_q[6:0], 1'b0} ^ (rcon_q[7] ? `AESD_POLY : 8'h00);
      end
      nw[0] = win_q[255:224] ^ kt;
      for (int i = 1; i < 4; i++) nw[i] = win_q[255-32*i -: 32] ^ nw[i-1];
      rk_d[kcnt_q+4'h1] = {nw[0], nw[1], nw[2], nw[3]};
      win_d = {win_q[127:0], nw[0], nw[1], nw[2], nw[3]};
      kcnt_d = kcnt_q + 4'h1;
      kbusy_d = (kcnt_q != `AESD_KEY_LAST); // [R5] [R7]
      kdone_d = (kcnt_q == `AESD_KEY_LAST); // [R6]
      if (kcnt_q == `AESD_KEY_LAST) key_ready_d = 1'b1;
    end else begin
      kcnt_d = 4'h0; // [R8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin // [R1]
      kcnt_q <= 4'h0;
      kbusy_q <= 1'b0;
      kdone_q <= 1'b0;
      rcon_q <= `AESD_RCON_INIT;
      win_q <= '0;
      key_ready_q <= 1'b0;
      for (int i = 0; i < 15; i++) rk_q[i] <= '0;
    end else begin
      kcnt_q <= kcnt_d;
      kbusy_q <= kbusy_d;
      kdone_q <= kdone_d;
      rcon_q <= rcon_d;
      win_q <= win_d;
      key_ready_q <= key_ready_d;
      for (int i = 0; i < 15; i++) rk_q[i] <= rk_d[i];
    end
  end

  // decryption pipeline, fifteen stages
  always_comb begin
    st_d[0] = ciphertext_block ^ rk_q[`AESD_NR]; // [R9] [R19]
    for (int i = 1; i < 15; i++) begin
      st_d[i] = inv_round(st_q[i-1], rk_q[14-i], i == `AESD_NR); // [R19]
    end
    vld_d = {vld_q[13:0], ct_acc}; // [R14]
  end

  // busy and drain tracking
  always_comb begin
    dbusy_d = dbusy_q;
    idle_d = idle_q;
    drain_d = 1'b0;
    if (ct_acc) begin
      dbusy_d = 1'b1; // [R12]
      idle_d = 4'h0;
    end else if (dbusy_q) begin
      if (idle_q == DRAIN_CMP) drain_d = 1'b1; // [R16]
      if (idle_q <= DRAIN_CMP) idle_d = idle_q + 4'h1;
      if (drain_q) dbusy_d = 1'b0; // [R17]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 15; i++) st_q[i] <= '0;
      vld_q <= '0;
      dbusy_q <= 1'b0;
      idle_q <= 4'h0;
      drain_q <= 1'b0;
    end else begin
      for (int i = 0; i < 15; i++) st_q[i] <= st_d[i];
      vld_q <= vld_d;
      dbusy_q <= dbusy_d;
      idle_q <= idle_d;
      drain_q <= drain_d;
    end
  end

  assign revision = REVISION; // [R2]
  assign key_expand_busy = kbusy_q;
  assign key_expand_done = kdone_q;
  assign decrypt_busy = dbusy_q;
  assign drain_done_pulse = drain_q;
  assign plaintext_valid = vld_q[14]; // [R14] [R15]
  assign plaintext_block = st_q[14];
  // axi4-lite slave
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, wstrb0_q, wstrb0_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    en_d = en_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `AESD_RESP_OKAY;
      if (awaddr_q == `AESD_OFF_CTRL) begin
        if (wstrb0_q) en_d = wdata_q[0];
      end else if (awaddr_q != `AESD_OFF_REV && awaddr_q != `AESD_OFF_STAT) begin
        bresp_d = `AESD_RESP_SLVERR;
      end
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = `AESD_RESP_OKAY;
      unique case (s_axi_araddr)
        `AESD_OFF_REV: rdata_d = REVISION;
        `AESD_OFF_CTRL: rdata_d = {31'h0, en_q};
        `AESD_OFF_STAT: rdata_d = {28'h0, dbusy_q, key_ready_q, kdone_q, kbusy_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `AESD_RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `AESD_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `AESD_RESP_OKAY;
      rdata_q <= 32'h0;
      en_q <= `AESD_CTRL_RST;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      en_q <= en_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule // aesd_top

// *** verification/aesd_top_sva.sv ***
// port assertions for the aes-256 decryptor
`timescale 1ns/1ps
`include "aesd_consts.svh"
module aesd_sva #(
  parameter logic [31:0] REVISION = `AESD_REVISION
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core ports
  input wire logic [31:0] revision,
  input wire logic key_load_strobe,
  input wire logic key_expand_busy,
  input wire logic key_expand_done,
  input wire logic ct_valid_strobe,
  input wire logic decrypt_busy,
  input wire logic drain_done_pulse,
  input wire logic plaintext_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_key;
    key_load_strobe && !key_expand_busy && !decrypt_busy && !ct_valid_strobe |=>
      key_expand_busy [*8] ##1 key_expand_busy [*5] ##1 key_expand_done && !key_expand_busy;
  endproperty
  a_key: assert property (p_key) else $error("key timing");
  property p_done;
    key_expand_done |-> $past(key_expand_busy) ##1 !key_expand_done;
  endproperty
  a_done: assert property (p_done) else $error("key done pulse");
  property p_busy;
    ct_valid_strobe && !key_expand_busy |=> decrypt_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("decrypt busy rise");
  property p_lat;
    ct_valid_strobe && !key_expand_busy |-> ##15 plaintext_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("plaintext latency");
  property p_drop;
    ct_valid_strobe && key_expand_busy |-> ##15 !plaintext_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("block not dropped");
  property p_valid;
    plaintext_valid |-> $past(ct_valid_strobe, 15) && !$past(key_expand_busy, 15);
  endproperty
  a_valid: assert property (p_valid) else $error("spurious plaintext");
  property p_drain;
    drain_done_pulse |-> plaintext_valid && !$past(ct_valid_strobe);
  endproperty
  a_drain: assert property (p_drain) else $error("drain pulse");
  property p_clear;
    drain_done_pulse && !ct_valid_strobe |=> !decrypt_busy && !drain_done_pulse;
  endproperty
  a_clear: assert property (p_clear) else $error("busy not cleared");
  property p_lock;
    key_load_strobe && decrypt_busy |=> !key_expand_busy;
  endproperty
  a_lock: assert property (p_lock) else $error("key taken while busy");
  property p_rev;
    revision == REVISION;
  endproperty
  a_rev: assert property (p_rev) else $error("revision");
endmodule // aesd_sva
bind aesd_top aesd_sva #(.REVISION(REVISION)) aesd_sva_inst (.aclk, .aresetn, .revision,
  .key_load_strobe, .key_expand_busy, .key_expand_done, .ct_valid_strobe, .decrypt_busy,
  .drain_done_pulse, .plaintext_valid);

// *** verification/aesd_user_model.sv ***
// user-side model feeding keys and ciphertext blocks
`timescale 1ns/1ps
module aesd_user_model (
  // clock
  input wire logic aclk,
  // key loading
  output logic key_load_strobe,
  output logic [255:0] key_value,
  // ciphertext
  output logic ct_valid_strobe,
  output logic [127:0] ciphertext_block
);
  initial begin
    key_load_strobe = 1'b0;
    key_value = '0;
    ct_valid_strobe = 1'b0;
    ciphertext_block = '0;
  end
  // key only good in its strobe cycle
  task automatic load(input logic [255:0] k);
    key_load_strobe <= 1'b1;
    key_value <= k;
    @(posedge aclk);
    key_load_strobe <= 1'b0;
    key_value <= ~k;
  endtask
  task automatic put(input logic [127:0] b);
    ct_valid_strobe <= 1'b1;
    ciphertext_block <= b;
    @(posedge aclk);
  endtask
  task automatic rest();
    ct_valid_strobe <= 1'b0;
    ciphertext_block <= ~ciphertext_block;
    @(posedge aclk);
  endtask
endmodule // aesd_user_model

// *** verification/testbench.sv ***
// self-checking bench of the aes-256 decryptor
`timescale 1ns/1ps
`include "aesd_consts.svh"
module testbench import aesd_pkg::*;;
  typedef struct packed {
    aesd_blk_t ct;
    aesd_blk_t pt;
  } aesd_row_s;
  localparam KEY_A = 256'h603DEB1015CA71BE2B73AEF0857D77811F352C073B6108D72D9810A30914DFF4;
  localparam KEY_B = 256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
  localparam CT_B = 128'h8EA2B7CA516745BFEAFC49904B496089;
  localparam PT_B = 128'h00112233445566778899AABBCCDDEEFF;
  localparam aesd_row_s ROWS [4] = '{
    '{128'hF3EED1BDB5D2A03C064B5A7E3DB181F8, 128'h6BC1BEE22E409F96E93D7E117393172A},
    '{128'h591CCB10D410ED26DC5BA74A31362870, 128'hAE2D8A571E03AC9C9EB76FAC45AF8E51},
    '{128'hB6ED21B99CA6F4F9F153E7B1BEAFED1D, 128'h30C81C46A35CE411E5FBC1191A0A52EF},
    '{128'h23304B7A39F9F3FF067D8D8F9E24ECC7, 128'hF69F2445DF4F9B17AD2B417BE66C3710}};
  logic aclk, aresetn, key_load_strobe, key_expand_busy, key_expand_done, ct_valid_strobe;
  logic decrypt_busy, drain_done_pulse, plaintext_valid;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] revision, s_axi_wdata, s_axi_rdata, rd;
  logic [255:0] key_value;
  aesd_blk_t ciphertext_block, plaintext_block;
  aesd_blk_t got_q[$], exp_q[$];
  int errors, checks, nd, n, d;
  aesd_top aesd_top_inst (.aclk, .aresetn, .revision, .key_load_strobe, .key_value,
    .key_expand_busy, .key_expand_done, .ct_valid_strobe, .ciphertext_block, .decrypt_busy,
    .drain_done_pulse, .plaintext_valid, .plaintext_block, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  aesd_user_model usr (.aclk, .key_load_strobe, .key_value, .ct_valid_strobe,
    .ciphertext_block);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (plaintext_valid === 1'b1) got_q.push_back(plaintext_block);
    if (drain_done_pulse === 1'b1) nd++;
  end
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h got %h", name, exp, got);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa | pw) begin
      @(posedge aclk);
      pa = pa & (s_axi_awready !== 1'b1);
      pw = pw & (s_axi_wready !== 1'b1);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic conclude();
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    conclude();
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("idle", 0, {key_expand_busy, decrypt_busy, plaintext_valid});
    axw(`AESD_OFF_CTRL, 32'h00000000, rs);
    chk("ctrl_resp", `AESD_RESP_OKAY, rs);
    axr(`AESD_OFF_CTRL, rd, rs);
    chk("ctrl_off", 32'h00000000, rd);
    axw(`AESD_OFF_CTRL, 32'h00000001, rs);
    axr(`AESD_OFF_CTRL, rd, rs);
    chk("ctrl_on", 32'h00000001, rd);
    axw(4'hC, 32'h00000001, rs);
    chk("unmapped_wr", `AESD_RESP_SLVERR, rs);
    axr(`AESD_OFF_REV, rd, rs);
    chk("rev_reg", `AESD_REVISION, rd);
    chk("revision", `AESD_REVISION, revision);
    axr(4'hC, rd, rs);
    chk("unmapped", `AESD_RESP_SLVERR, rs);
    usr.load(KEY_A);
    repeat (16) begin
      @(posedge aclk);
      n += key_expand_busy;
      d += key_expand_done;
    end
    chk("key_busy", 13, n);
    chk("key_done", 1, d);
    axr(`AESD_OFF_STAT, rd, rs);
    chk("status", 32'h4, rd);
    nd = 0;
    foreach (ROWS[i]) begin
      usr.put(ROWS[i].ct);
      exp_q.push_back(ROWS[i].pt);
    end
    usr.rest();
    usr.load(KEY_B);
    repeat (20) @(posedge aclk);
    chk("drains", 1, nd);
    chk("busy_end", 0, decrypt_busy);
    usr.put(ROWS[0].ct);
    exp_q.push_back(ROWS[0].pt);
    usr.rest();
    repeat (20) @(posedge aclk);
    usr.load(KEY_B);
    usr.rest();
    usr.put(CT_B);
    usr.rest();
    usr.load(KEY_A);
    repeat (12) @(posedge aclk);
    usr.put(CT_B);
    exp_q.push_back(PT_B);
    usr.rest();
    repeat (20) @(posedge aclk);
    chk("out_count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) chk("plaintext", exp_q[i], got_q[i]);
    usr.put(CT_B);
    usr.rest();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("flushed", exp_q.size(), got_q.size());
    chk("busy_rst", 0, decrypt_busy);
    conclude();
  end
endmodule // testbench
